// [inc/smcg_regs.vh]
`ifndef SMCG_REGS_VH
`define SMCG_REGS_VH
// sleep mode field codes
`define SMCG_MODE_IDLE 3'h0
`define SMCG_MODE_NRED 3'h1
`define SMCG_MODE_PDOWN 3'h2
`define SMCG_MODE_PSAVE 3'h3
`define SMCG_MODE_STBY 3'h6
// fixed wake latencies in cycles
`define SMCG_HOLD_CYCLES 4'h4
`define SMCG_STBY_CYCLES 4'h6
// width of the stabilisation counter
`define SMCG_STAB_W 16
`define SMCG_GATE_W 8
// wake source vector bit positions
`define SMCG_WK_ANY_IRQ 0
`define SMCG_WK_CONV 1
`define SMCG_WK_WDOG 2
`define SMCG_WK_TWI 3
`define SMCG_WK_T2 4
`define SMCG_WK_STORE 5
`define SMCG_WK_LEVEL 6
`define SMCG_WK_EDGE 7
`define SMCG_WK_PCHG 8
`define SMCG_WK_W 9
`endif

// [core/smcg_wake_filter.v]
`timescale 1ns/1ns
`include "smcg_regs.vh"
// ---------------------------------------------
// wake qualification per sleep mode
// ---------------------------------------------
module smcg_wake_filter (
	input wire [2:0] mode,
	input wire [`SMCG_WK_W-1:0] src,
	input wire t2_irq_ok,
	output reg wake
);
	// combinational filter: which sources may end the current sleep
	always @* begin
		wake = 1'b0;
		case (mode)
			`SMCG_MODE_IDLE: begin
				wake = src[`SMCG_WK_ANY_IRQ];
			end
			`SMCG_MODE_NRED: begin
				// edge irqs excluded outside idle
				wake = src[`SMCG_WK_CONV] | src[`SMCG_WK_WDOG] | src[`SMCG_WK_TWI] | src[`SMCG_WK_T2]
					| src[`SMCG_WK_STORE] | src[`SMCG_WK_LEVEL] | src[`SMCG_WK_PCHG];
			end
			`SMCG_MODE_PSAVE: begin
				wake = src[`SMCG_WK_WDOG] | src[`SMCG_WK_TWI] | src[`SMCG_WK_LEVEL] | src[`SMCG_WK_PCHG]
					| (src[`SMCG_WK_T2] & t2_irq_ok);
			end
			default: begin
				// power-down and standby share the asynchronous set
				wake = src[`SMCG_WK_WDOG] | src[`SMCG_WK_TWI] | src[`SMCG_WK_LEVEL]
					| src[`SMCG_WK_PCHG];
			end
		endcase
	end
endmodule

// [core/smcg_gate_bank.v]
`timescale 1ns/1ns
`include "smcg_regs.vh"
// ---------------------------------------------
// per-peripheral clock enable bank
// ---------------------------------------------
module smcg_gate_bank (
	input wire CLK_SYS,
	input wire RST,
	input wire io_run,
	input wire [`SMCG_GATE_W-1:0] gate_bits,
	output wire [`SMCG_GATE_W-1:0] periph_en
);
	genvar g;
	// a gated module sees no enable, so its flops hold; clearing the bit resumes it
	// each bit has its own flop so that no vector is driven from several processes
	generate
		for (g = 0; g < `SMCG_GATE_W; g = g + 1) begin : gl
			reg en_reg; // enable flop of one peripheral
			always @(posedge CLK_SYS or posedge RST) begin
				if (RST) begin
					en_reg <= 1'b1;
				end else begin
					en_reg <= io_run & ~gate_bits[g];
				end
			end
			assign periph_en[g] = en_reg;
		end
	endgenerate
endmodule

// [core/smcg_sleep_ctrl.v]
`timescale 1ns/1ns
`include "smcg_regs.vh"
module smcg_sleep_ctrl (
	input wire CLK_SYS,
	input wire RST,
	input wire HALT_EXEC,
	input wire SLEEP_ARM,
	input wire [2:0] SLEEP_MODE_SEL,
	input wire XTAL_SELECTED,
	input wire [`SMCG_STAB_W-1:0] STARTUP_CYCLES,
	input wire CONV_ENABLED,
	input wire T2_ENABLED,
	input wire T2_ASYNC,
	input wire T2_IRQ_OK,
	input wire [`SMCG_WK_W-1:0] WAKE_SRC,
	input wire [`SMCG_GATE_W-1:0] MODULE_CLOCK_GATE,
	output reg CORE_CLOCK_EN,
	output reg PROGRAM_STORE_CLOCK_EN,
	output reg PERIPHERAL_IO_CLOCK_EN,
	output reg CONVERTER_CLOCK_EN,
	output reg ASYNC_TIMER_CLOCK_EN,
	output reg MAIN_OSC_EN,
	output reg TIMER_OSC_EN,
	output reg T2_SYNC_CLOCK_EN,
	output reg CONV_START,
	output reg WAKE_IRQ,
	output reg ASLEEP,
	output reg [2:0] ACTIVE_MODE,
	output wire [`SMCG_GATE_W-1:0] PERIPH_CLOCK_EN
);
	// ---------------------------------------------
	// state machine
	// ---------------------------------------------
	localparam ST_RUN = 4'b0001; // executing
	localparam ST_SLEEP = 4'b0010; // clocks stopped per mode
	localparam ST_STAB = 4'b0100; // oscillator restart wait
	localparam ST_HOLD = 4'b1000; // fixed core hold after wake

	// registered state, latched sleep code and one shared down-counter
	reg [3:0] state_reg, state_next;
	reg [2:0] mode_reg, mode_next;
	reg [`SMCG_STAB_W-1:0] cnt_reg, cnt_next;
	wire wake_ok; // qualified wake from the filter

	// counter load values; the counter is shared by stabilisation and hold
	wire [`SMCG_STAB_W-1:0] cnt_one = {{(`SMCG_STAB_W-1){1'b0}}, 1'b1}; // last count of a phase
	wire [`SMCG_STAB_W-1:0] hold_load = {{(`SMCG_STAB_W-4){1'b0}}, `SMCG_HOLD_CYCLES}; // core hold after a wake
	wire [`SMCG_STAB_W-1:0] stby_load = {{(`SMCG_STAB_W-4){1'b0}}, `SMCG_STBY_CYCLES}; // standby restart latency

	// decode: mode code names a real sleep state
	function mode_valid;
		input [2:0] m;
		input xtal;
		begin
			mode_valid = (m == `SMCG_MODE_IDLE) | (m == `SMCG_MODE_NRED) | (m == `SMCG_MODE_PDOWN)
				| (m == `SMCG_MODE_PSAVE) | ((m == `SMCG_MODE_STBY) & xtal);
		end
	endfunction

	// decode: power-down or power-save, which may have stopped the main oscillator, so start-up time applies
	function osc_stopped;
		input [2:0] m;
		begin
			osc_stopped = (m == `SMCG_MODE_PDOWN) | (m == `SMCG_MODE_PSAVE);
		end
	endfunction

	// decode: timer 2 enabled and clocked from the synchronous source
	function t2_sync_only;
		input en;
		input async_sel;
		begin
			t2_sync_only = en & ~async_sel;
		end
	endfunction

	// qualification works on the latched mode, not on the live field
	smcg_wake_filter u_filter (
		.mode(mode_reg),
		.src(WAKE_SRC),
		.t2_irq_ok(T2_IRQ_OK),
		.wake(wake_ok)
	);

	// ---------------------------------------------
	// next-state logic
	// ---------------------------------------------
	// level sources must persist until sampled here; a brief pulse may be missed
	always @* begin
		state_next = state_reg;
		mode_next = mode_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_RUN: begin
				// armed halt with valid code enters sleep
				// any other halt is ignored and changes no port
				if (HALT_EXEC && SLEEP_ARM && mode_valid(SLEEP_MODE_SEL, XTAL_SELECTED)) begin
					state_next = ST_SLEEP;
					mode_next = SLEEP_MODE_SEL;
				end
			end
			ST_SLEEP: begin
				// only sources the filter passes for this mode end the sleep
				if (wake_ok) begin
					if (osc_stopped(mode_reg)) begin
						// power-down or power-save: wait the selected start-up time
						state_next = ST_STAB;
						cnt_next = STARTUP_CYCLES;
					end else if (mode_reg == `SMCG_MODE_STBY) begin
						// oscillator kept running: short fixed restart
						state_next = ST_STAB;
						cnt_next = stby_load;
					end else begin
						// idle and noise mode: the source never stopped
						state_next = ST_HOLD;
						cnt_next = hold_load;
					end
				end
			end
			ST_STAB: begin
				// every mode, standby included, adds the hold once the restart wait ends
				// a start-up count of zero is treated as one cycle
				if (cnt_reg <= cnt_one) begin
					state_next = ST_HOLD;
					cnt_next = hold_load;
				end else begin
					// one cycle of the restart wait used up
					cnt_next = cnt_reg - cnt_one;
				end
			end
			ST_HOLD: begin
				// core still halted; resume once the hold has run out
				if (cnt_reg <= cnt_one) begin
					state_next = ST_RUN;
					cnt_next = {`SMCG_STAB_W{1'b0}};
				end else begin
					// one hold cycle used up
					cnt_next = cnt_reg - cnt_one;
				end
			end
			// unused one-hot codes fall back to run
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// ---------------------------------------------
	// state registers
	// ---------------------------------------------
	// async reset aborts any sleep; core restarts from vector
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_reg <= ST_RUN;
			mode_reg <= `SMCG_MODE_IDLE;
			cnt_reg <= {`SMCG_STAB_W{1'b0}};
		end else begin
			// state, mode and counter move together on each edge
			state_reg <= state_next;
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
		end
	end

	// ---------------------------------------------
	// clock domain enables
	// ---------------------------------------------
	// decoded from the next state so the registered enables change with the state
	wire sleep_next = (state_next == ST_SLEEP);
	wire run_next = (state_next == ST_RUN);
	wire entering = (state_reg == ST_RUN) & sleep_next;

	// enables while asleep, 1 = running (core and store always off):
	//   idle     io 1, conv 1, async 1, main 1, timer osc if timer 2 async
	//   noise    io 0, conv 1, async 1, main 1, timer osc if timer 2 async
	//   pdown    io 0, conv 0, async 0, main 0, timer osc 0
	//   psave    io 0, conv 0, async 1, main only for synchronous timer 2, timer osc 1
	//   standby  io 0, conv 0, async 0, main 1, timer osc 0
	// reserved codes never reach sleep, so they need no row
	always @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			// reset leaves every domain running; timer oscillator waits for its select
			CORE_CLOCK_EN <= 1'b1;
			PROGRAM_STORE_CLOCK_EN <= 1'b1;
			PERIPHERAL_IO_CLOCK_EN <= 1'b1;
			CONVERTER_CLOCK_EN <= 1'b1;
			ASYNC_TIMER_CLOCK_EN <= 1'b1;
			MAIN_OSC_EN <= 1'b1;
			TIMER_OSC_EN <= 1'b0;
			T2_SYNC_CLOCK_EN <= 1'b1;
			CONV_START <= 1'b0;
			WAKE_IRQ <= 1'b0;
			ASLEEP <= 1'b0;
			ACTIVE_MODE <= `SMCG_MODE_IDLE;
		end else begin
			// core and store run only in run state; halted in hold too
			CORE_CLOCK_EN <= run_next;
			PROGRAM_STORE_CLOCK_EN <= run_next;
			// status follows the next state so it changes with the enables
			ASLEEP <= sleep_next;
			ACTIVE_MODE <= mode_next;
			// interrupt flag to core when hold ends so it runs the handler
			WAKE_IRQ <= (state_reg == ST_HOLD) & run_next;
			// conversion kicked on entry to idle or noise mode
			CONV_START <= entering & CONV_ENABLED & ((SLEEP_MODE_SEL == `SMCG_MODE_IDLE)
				| (SLEEP_MODE_SEL == `SMCG_MODE_NRED));
			if (!sleep_next) begin
				// awake or waking: oscillator back, clocks back
				PERIPHERAL_IO_CLOCK_EN <= 1'b1;
				CONVERTER_CLOCK_EN <= 1'b1;
				ASYNC_TIMER_CLOCK_EN <= 1'b1;
				MAIN_OSC_EN <= 1'b1;
				TIMER_OSC_EN <= T2_ASYNC;
				T2_SYNC_CLOCK_EN <= 1'b1;
			end else begin
				case (mode_next)
					// idle: only core and store stop
					`SMCG_MODE_IDLE: begin
						PERIPHERAL_IO_CLOCK_EN <= 1'b1;
						CONVERTER_CLOCK_EN <= 1'b1;
						ASYNC_TIMER_CLOCK_EN <= 1'b1;
						MAIN_OSC_EN <= 1'b1;
						TIMER_OSC_EN <= T2_ASYNC;
						T2_SYNC_CLOCK_EN <= 1'b1;
					end
					// noise reduction: io stops as well, converter keeps running
					`SMCG_MODE_NRED: begin
						PERIPHERAL_IO_CLOCK_EN <= 1'b0;
						CONVERTER_CLOCK_EN <= 1'b1;
						ASYNC_TIMER_CLOCK_EN <= 1'b1;
						MAIN_OSC_EN <= 1'b1;
						TIMER_OSC_EN <= T2_ASYNC;
						T2_SYNC_CLOCK_EN <= 1'b0;
					end
					// power-save: like power-down but timer 2 keeps its clock
					`SMCG_MODE_PSAVE: begin
						PERIPHERAL_IO_CLOCK_EN <= 1'b0;
						CONVERTER_CLOCK_EN <= 1'b0;
						ASYNC_TIMER_CLOCK_EN <= 1'b1;
						// main source off unless timer 2 runs from it
						MAIN_OSC_EN <= t2_sync_only(T2_ENABLED, T2_ASYNC);
						TIMER_OSC_EN <= 1'b1;
						T2_SYNC_CLOCK_EN <= t2_sync_only(T2_ENABLED, T2_ASYNC);
					end
					// standby: like power-down but the oscillator stays up
					`SMCG_MODE_STBY: begin
						PERIPHERAL_IO_CLOCK_EN <= 1'b0;
						CONVERTER_CLOCK_EN <= 1'b0;
						ASYNC_TIMER_CLOCK_EN <= 1'b0;
						MAIN_OSC_EN <= 1'b1;
						TIMER_OSC_EN <= 1'b0;
						T2_SYNC_CLOCK_EN <= 1'b0;
					end
					default: begin
						// power-down: everything generated stops
						PERIPHERAL_IO_CLOCK_EN <= 1'b0;
						CONVERTER_CLOCK_EN <= 1'b0;
						ASYNC_TIMER_CLOCK_EN <= 1'b0;
						MAIN_OSC_EN <= 1'b0;
						TIMER_OSC_EN <= 1'b0;
						T2_SYNC_CLOCK_EN <= 1'b0;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------
	// per-module gating
	// ---------------------------------------------
	// io clock is running only in active, idle and the wake sequence
	wire io_run_next = ~sleep_next | (mode_next == `SMCG_MODE_IDLE);

	// gating bits act only while io runs; deeper modes stop those clocks anyway
	// a peripheral still busy when gated keeps its resources until ungated
	smcg_gate_bank u_gates (
		.CLK_SYS(CLK_SYS),
		.RST(RST),
		.io_run(io_run_next),
		.gate_bits(MODULE_CLOCK_GATE),
		.periph_en(PERIPH_CLOCK_EN)
	);
endmodule

// [verif/smcg_core_model.sv]
`timescale 1ns/1ns
// ----
// core side: issues halt, counts wake irqs
// ----
module smcg_core_model (
	input logic clk,
	input logic rst,
	input logic go,
	input logic core_en,
	input logic wake_irq,
	output logic halt,
	output int wakes
);
	// a stopped core executes nothing, so halt only while clocked
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			halt <= 1'b0;
			wakes <= 0;
		end else begin
			// one-cycle halt, never two in a row
			halt <= go && core_en && !halt;
			wakes <= wakes + wake_irq;
		end
	end
endmodule

// [verif/smcg_monitor.sv]
`timescale 1ns/1ns
// ----
// sleep entry and wake checks
// ----
module smcg_monitor (
	input logic CLK_SYS,
	input logic RST,
	input logic HALT_EXEC,
	input logic SLEEP_ARM,
	input logic [2:0] SLEEP_MODE_SEL,
	input logic CONV_ENABLED,
	input logic [8:0] WAKE_SRC,
	input logic [7:0] MODULE_CLOCK_GATE,
	input logic CORE_CLOCK_EN,
	input logic PERIPHERAL_IO_CLOCK_EN,
	input logic CONVERTER_CLOCK_EN,
	input logic MAIN_OSC_EN,
	input logic CONV_START,
	input logic WAKE_IRQ,
	input logic ASLEEP,
	input logic [2:0] ACTIVE_MODE,
	input logic [7:0] PERIPH_CLOCK_EN
);
	wire [2:0] m = SLEEP_MODE_SEL;
	// a halt only counts while the core is clocked and awake
	wire run = HALT_EXEC && CORE_CLOCK_EN && !ASLEEP;
	wire tk = run && SLEEP_ARM;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	chk_idle_entry: assert property (tk && m == 3'h0 |=> ASLEEP && !CORE_CLOCK_EN && PERIPHERAL_IO_CLOCK_EN)
		else $error("idle entry wrong");
	chk_noise_entry: assert property (tk && m == 3'h1 |=> ASLEEP && !PERIPHERAL_IO_CLOCK_EN
		&& CONVERTER_CLOCK_EN && MAIN_OSC_EN) else $error("noise entry wrong");
	chk_pdown_entry: assert property (tk && m == 3'h2 |=> ASLEEP && !MAIN_OSC_EN && !CONVERTER_CLOCK_EN)
		else $error("power-down entry wrong");
	chk_halt_refused: assert property (run && (!SLEEP_ARM || m[2] && m != 3'h6) |=> !ASLEEP && CORE_CLOCK_EN)
		else $error("refused halt slept");
	chk_conv_start: assert property (tk && !m[2] && !m[1] && CONV_ENABLED |=> CONV_START)
		else $error("no conversion start");
	chk_idle_wake: assert property (ASLEEP && ACTIVE_MODE == 3'h0 && WAKE_SRC[0] |=> !ASLEEP && !CORE_CLOCK_EN
		##1 !CORE_CLOCK_EN [*3] ##1 CORE_CLOCK_EN && WAKE_IRQ) else $error("idle wake timing wrong");
	chk_io_back: assert property ($fell(ASLEEP) |-> PERIPHERAL_IO_CLOCK_EN && MAIN_OSC_EN)
		else $error("clocks not back on wake");
	chk_gate_bits: assert property (PERIPHERAL_IO_CLOCK_EN && $past(PERIPHERAL_IO_CLOCK_EN) && !$past(RST)
		|-> PERIPH_CLOCK_EN == ~$past(MODULE_CLOCK_GATE)) else $error("module gate wrong");
	cov_psave: cover property (tk && m == 3'h3);
	cov_wake: cover property (WAKE_IRQ);
	cov_edge: cover property (ASLEEP && WAKE_SRC[7]);
endmodule
bind smcg_sleep_ctrl smcg_monitor u_mon (.CLK_SYS(CLK_SYS), .RST(RST), .HALT_EXEC(HALT_EXEC),
	.SLEEP_ARM(SLEEP_ARM), .SLEEP_MODE_SEL(SLEEP_MODE_SEL), .CONV_ENABLED(CONV_ENABLED),
	.WAKE_SRC(WAKE_SRC), .MODULE_CLOCK_GATE(MODULE_CLOCK_GATE), .CORE_CLOCK_EN(CORE_CLOCK_EN),
	.PERIPHERAL_IO_CLOCK_EN(PERIPHERAL_IO_CLOCK_EN), .CONVERTER_CLOCK_EN(CONVERTER_CLOCK_EN),
	.MAIN_OSC_EN(MAIN_OSC_EN), .CONV_START(CONV_START), .WAKE_IRQ(WAKE_IRQ), .ASLEEP(ASLEEP),
	.ACTIVE_MODE(ACTIVE_MODE), .PERIPH_CLOCK_EN(PERIPH_CLOCK_EN));

// [verif/tb_top.sv]
`timescale 1ns/1ns
// ----
// sleep controller bench
// ----
module tb_top;
	logic clk = 0, rst = 1, go = 0, arm = 0, xtal = 0, conv = 0, t2e = 0, t2a = 0, t2k = 0;
	logic [2:0] sel = 0;
	logic [15:0] stc = 16'h0005;
	logic [8:0] src = 0;
	logic [7:0] gate = 0;
	wire halt, t2s, cst, wirq, slp;
	wire [6:0] dom; // core store io conv async main tosc
	wire [2:0] amode;
	wire [7:0] pen;
	int wakes, fail_count = 0, comparisons = 0, n;
	smcg_sleep_ctrl u_dut (.CLK_SYS(clk), .RST(rst), .HALT_EXEC(halt), .SLEEP_ARM(arm), .SLEEP_MODE_SEL(sel),
		.XTAL_SELECTED(xtal), .STARTUP_CYCLES(stc), .CONV_ENABLED(conv), .T2_ENABLED(t2e), .T2_ASYNC(t2a),
		.T2_IRQ_OK(t2k), .WAKE_SRC(src), .MODULE_CLOCK_GATE(gate), .CORE_CLOCK_EN(dom[6]),
		.PROGRAM_STORE_CLOCK_EN(dom[5]), .PERIPHERAL_IO_CLOCK_EN(dom[4]), .CONVERTER_CLOCK_EN(dom[3]),
		.ASYNC_TIMER_CLOCK_EN(dom[2]), .MAIN_OSC_EN(dom[1]), .TIMER_OSC_EN(dom[0]), .T2_SYNC_CLOCK_EN(t2s),
		.CONV_START(cst), .WAKE_IRQ(wirq), .ASLEEP(slp), .ACTIVE_MODE(amode), .PERIPH_CLOCK_EN(pen));
	smcg_core_model u_core (.clk(clk), .rst(rst), .go(go), .core_en(dom[6]), .wake_irq(wirq), .halt(halt),
		.wakes(wakes));
	initial begin
		forever #20 clk = ~clk;
	end
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	// arm, then one halt from the core; returns once entry has landed
	task sleep_in(input logic [2:0] m, input logic a);
		sel = m;
		arm = a;
		go = 1;
		@(negedge clk);
		go = 0;
		@(negedge clk);
	endtask
	// level source is held until the controller has left sleep
	task wake(input logic [8:0] b);
		src = b;
		n = 0;
		while (wirq !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
			if (slp === 1'b0) src = 0;
		end
		src = 0;
	endtask
	task stay(input logic [8:0] b);
		src = b;
		repeat (3) @(negedge clk);
		chk("asleep", 1, slp);
		src = 0;
	endtask
	task t_gate;
		gate = 8'h81; // no gated peripheral is busy here
		repeat (2) @(negedge clk);
		chk("pen", 8'h7E, pen);
		gate = 0;
		repeat (2) @(negedge clk);
		chk("pen", 8'hFF, pen);
	endtask
	task t_idle;
		int w;
		w = wakes;
		t2a = 1;
		conv = 1;
		gate = 8'h05;
		sleep_in(3'h0, 1);
		chk("dom", 7'h1F, dom);
		chk("cst", 1, cst);
		chk("pen", 8'hFA, pen);
		wake(9'h001);
		chk("n", 5, n);
		// the core counts the pulse at the edge after it appears
		@(negedge clk);
		chk("wakes", 1, wakes - w);
		t2a = 0;
		gate = 0;
	endtask
	task t_noise;
		sleep_in(3'h1, 1);
		chk("dom", 7'h0E, dom);
		chk("cst", 1, cst);
		chk("pen", 8'h00, pen);
		chk("amode", 3'h1, amode);
		stay(9'h080);
		wake(9'h002);
		chk("n", 5, n);
		conv = 0;
	endtask
	task t_pdown;
		sleep_in(3'h2, 1);
		chk("dom", 7'h00, dom);
		stay(9'h0B3);
		wake(9'h040);
		chk("n", 1, n >= 9 && n <= 11);
	endtask
	task t_psave;
		t2e = 1;
		t2a = 1;
		t2k = 1;
		sleep_in(3'h3, 1);
		chk("dom", 7'h05, dom);
		chk("t2s", 0, t2s);
		wake(9'h011);
		chk("n", 1, n >= 9 && n <= 11);
		// timer 2 on the synchronous clock: main source must stay up for it
		t2a = 0;
		sleep_in(3'h3, 1);
		chk("dom", 7'h07, dom);
		chk("t2s", 1, t2s);
		wake(9'h010);
		chk("n", 1, n >= 9 && n <= 11);
		t2e = 0;
		t2a = 0;
	endtask
	task t_stby;
		xtal = 1;
		sleep_in(3'h6, 1);
		chk("dom", 7'h02, dom);
		wake(9'h004);
		chk("n", 1, n >= 10 && n <= 12);
	endtask
	task t_refuse;
		logic [2:0] rm [5];
		rm = '{3'h4, 3'h5, 3'h7, 3'h6, 3'h0};
		xtal = 0;
		for (int i = 0; i < 5; i++) begin
			sleep_in(rm[i], i < 4);
			chk("refused", 8'h7E, {slp, dom});
		end
	endtask
	task t_reset;
		sleep_in(3'h2, 1);
		rst = 1;
		@(negedge clk);
		rst = 0;
		@(negedge clk);
		chk("reset", 8'h7E, {slp, dom});
	endtask
	task give_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 0;
		@(negedge clk);
		t_gate;
		t_idle;
		t_noise;
		t_pdown;
		t_psave;
		t_stby;
		t_refuse;
		t_reset;
		give_verdict;
	end
	// about 2500 cycles, far beyond the run
	initial begin
		#100000;
		fail_count++;
		give_verdict;
	end
endmodule
